// ===== pkg/cis_defs.svh
// Constants for the instruction semantics core: offsets, fields, encodings, resets
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH

// Register port byte offsets
`define CIS_REG_INSTR   6'h00
`define CIS_REG_STATUS  6'h04
`define CIS_REG_ACC     6'h08
`define CIS_REG_SP      6'h0c
`define CIS_REG_DIR     6'h10
`define CIS_REG_XIDX    6'h14
`define CIS_REG_BANK    6'h18
`define CIS_REG_PC      6'h1c
`define CIS_REG_PSTAT   6'h20

// Status flag positions
`define CIS_P_N 7
`define CIS_P_V 6
`define CIS_P_M 5
`define CIS_P_X 4
`define CIS_P_D 3
`define CIS_P_I 2
`define CIS_P_Z 1
`define CIS_P_C 0

// Reset values
`define CIS_P_RST      8'h34
`define CIS_SP_RST     16'h01ff
`define CIS_EMU_PAGE   8'h01
`define CIS_STACK_DEPTH 256

// Opcode encodings
`define CIS_OP_BRK 8'h00
`define CIS_OP_COP 8'h02
`define CIS_OP_PHP 8'h08
`define CIS_OP_PLP 8'h28
`define CIS_OP_TCS 8'h1b
`define CIS_OP_TSC 8'h3b
`define CIS_OP_TCD 8'h5b
`define CIS_OP_TDC 8'h7b
`define CIS_OP_WDM 8'h42
`define CIS_OP_MVP 8'h44
`define CIS_OP_MVN 8'h54
`define CIS_OP_WAI 8'hcb
`define CIS_OP_TAX 8'haa
`define CIS_OP_TXA 8'h8a
`define CIS_OP_LDA 8'ha9
`define CIS_OP_SEP 8'he2
`define CIS_OP_REP 8'hc2
`define CIS_OP_XCE 8'hfb

// Instruction lengths in bytes
`define CIS_LEN1 16'h0001
`define CIS_LEN2 16'h0002
`define CIS_LEN3 16'h0003

// Handler vectors
`define CIS_VEC_RESET 16'hfffc
`define CIS_VEC_ABORT 16'hfff8
`define CIS_VEC_NMI   16'hfffa
`define CIS_VEC_IRQ   16'hfffe
`define CIS_VEC_BRK   16'hffe6
`define CIS_VEC_COP   16'hfff4

`endif

// ===== pkg/cis_pkg.sv
// Types for the instruction semantics core
package cis_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_exec  = 3'b001,
    st_push  = 3'b010,
    st_pull  = 3'b011,
    st_pulld = 3'b100,
    st_wait  = 3'b101,
    st_rst   = 3'b110
  } cis_state_t;

  typedef enum logic [2:0] {
    src_none  = 3'b000,
    src_abort = 3'b001,
    src_nmi   = 3'b010,
    src_irq   = 3'b011,
    src_brk   = 3'b100,
    src_cop   = 3'b101
  } cis_src_t;
endpackage

// ===== pkg/cis_stack_if.sv
// Stack memory port between the core and its stack RAM
`timescale 1ns/100ps
interface cis_stack_if;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ===== core/cis_stack_ram.sv
// Stack page RAM with registered read data
`timescale 1ns/100ps
`include "cis_defs.svh"
module cis_stack_ram (
  input wire logic    clk,
  cis_stack_if.mem    port
);
  logic [7:0] mem_ff [0:`CIS_STACK_DEPTH-1];

  // Read first port, read data one cycle after the address
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_ff[port.addr] <= port.wdata;
    end
    port.rdata <= mem_ff[port.addr];
  end
endmodule

// ===== core/cis_core.sv
// Instruction semantics core: register transfers, traps, waits and interrupt entry
// Overview of operation
// - reserved no-op opcode only advances program counter
// - low ready stalls exec, push and pull cycles, writes included
// - block moves load data bank from byte two
// - priority reset, abort, nonmaskable, then maskable
// - sources give 16 bits, destination width decides
// - accumulator stack/direct transfers always 16 bits
// - status push and pull are single bytes
// - emulation stack transfer forces high byte 01
// - native stack transfer copies accumulator upper byte
// - stack to accumulator copies all 16 bits
// - break skips its signature byte, two bytes
// - 8-bit accumulator keeps its upper byte
// - wait output goes low during wait instruction
// - nonmaskable, maskable or reset ends the wait
`timescale 1ns/100ps
`include "cis_defs.svh"
module cis_core (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        reset_input_low,
  input  wire logic        abort_input_low,
  input  wire logic        nonmaskable_irq_low,
  input  wire logic        maskable_irq_low,
  input  wire logic        bus_enable_in,
  input  wire logic        ready_input,
  output logic             wait_state_output_low,
  output logic             emulation_mode
);
  cis_pkg::cis_state_t state_ff;
  cis_pkg::cis_state_t nxt_state;
  cis_pkg::cis_src_t   src_ff;
  cis_pkg::cis_src_t   nxt_src;
  logic [15:0] acc_ff;
  logic [15:0] nxt_acc;
  logic [15:0] sp_ff;
  logic [15:0] nxt_sp;
  logic [15:0] dir_ff;
  logic [15:0] nxt_dir;
  logic [15:0] xr_ff;
  logic [15:0] nxt_xr;
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic [7:0]  dbr_ff;
  logic [7:0]  nxt_dbr;
  logic [7:0]  pbr_ff;
  logic [7:0]  nxt_pbr;
  logic [7:0]  p_ff;
  logic [7:0]  nxt_p;
  logic        emu_ff;
  logic        nxt_emu;
  logic [1:0]  cnt_ff;
  logic [1:0]  nxt_cnt;
  logic [7:0]  op_ff;
  logic [7:0]  op1_ff;
  logic [7:0]  op2_ff;
  logic        nmi_q_ff;
  logic        nmi_pend_ff;
  logic        abort_pend_ff;
  logic        refused_ff;
  logic [31:0] rdata_ff;
  logic        go;
  logic        m8;
  logic        x8;
  logic        idle_ok;
  logic        instr_wr;
  logic        accept;
  logic        nmi_take;
  logic        abort_take;
  logic        mem_we;
  logic [7:0]  mem_addr;
  logic [7:0]  mem_wdata;
  logic [15:0] vec;
  logic [31:0] rd_mux;

  cis_stack_if sif ();

  cis_stack_ram u_ram (
    .clk  (clk),
    .port (sif.mem)
  );

  assign sif.we    = mem_we;
  assign sif.addr  = mem_addr;
  assign sif.wdata = mem_wdata;

  // A stall holds the exec, push and pull states, so a stack write is never half done
  assign go = ready_input & bus_enable_in;
  assign m8 = p_ff[`CIS_P_M];
  assign x8 = p_ff[`CIS_P_X];
  assign idle_ok  = (state_ff == cis_pkg::st_idle) & reset_input_low;
  assign instr_wr = reg_wr & (reg_addr == `CIS_REG_INSTR);
  assign wait_state_output_low = (state_ff != cis_pkg::st_wait);
  assign emulation_mode = emu_ff;
  assign reg_rdata = rdata_ff;

  // Negative and zero flags from a result of the destination width
  function automatic logic [7:0] set_nz(input logic [7:0] p, input logic [15:0] v, input logic wide);
    logic [7:0] r;
    r = p;
    r[`CIS_P_N] = wide ? v[15] : v[7];
    r[`CIS_P_Z] = wide ? (v == 16'h0000) : (v[7:0] == 8'h00);
    return r;
  endfunction

  // Emulation keeps the stack inside page one
  function automatic logic [15:0] sp_step(input logic [15:0] s, input logic e, input logic up);
    logic [15:0] r;
    r = up ? s + 16'h0001 : s - 16'h0001;
    if (e) begin
      r = {`CIS_EMU_PAGE, r[7:0]};
    end
    return r;
  endfunction

  // Handler address for the interrupt being entered
  always_comb begin
    case (src_ff)
      cis_pkg::src_abort: vec = `CIS_VEC_ABORT;
      cis_pkg::src_nmi:   vec = `CIS_VEC_NMI;
      cis_pkg::src_irq:   vec = `CIS_VEC_IRQ;
      cis_pkg::src_brk:   vec = `CIS_VEC_BRK;
      cis_pkg::src_cop:   vec = `CIS_VEC_COP;
      default:            vec = `CIS_VEC_IRQ;
    endcase
  end

  // Next architectural state
  always_comb begin
    nxt_state  = state_ff;
    nxt_src    = src_ff;
    nxt_acc    = acc_ff;
    nxt_sp     = sp_ff;
    nxt_dir    = dir_ff;
    nxt_xr     = xr_ff;
    nxt_pc     = pc_ff;
    nxt_dbr    = dbr_ff;
    nxt_pbr    = pbr_ff;
    nxt_p      = p_ff;
    nxt_emu    = emu_ff;
    nxt_cnt    = cnt_ff;
    accept     = 1'b0;
    nmi_take   = 1'b0;
    abort_take = 1'b0;
    mem_we     = 1'b0;
    mem_addr   = sp_ff[7:0];
    mem_wdata  = 8'h00;
    if (!reset_input_low) begin
      // Reset outranks everything and is held while the line is low
      nxt_state = cis_pkg::st_rst;
      nxt_src   = cis_pkg::src_none;
      nxt_emu   = 1'b1;
      nxt_p     = `CIS_P_RST;
      nxt_sp    = {`CIS_EMU_PAGE, sp_ff[7:0]};
      nxt_xr    = {8'h00, xr_ff[7:0]};
      nxt_dir   = 16'h0000;
      nxt_dbr   = 8'h00;
      nxt_pbr   = 8'h00;
    end else begin
      case (state_ff)
        cis_pkg::st_rst: begin
          nxt_pc    = `CIS_VEC_RESET;
          nxt_state = cis_pkg::st_idle;
        end
        cis_pkg::st_idle: begin
          if (abort_pend_ff || !abort_input_low) begin
            abort_take = 1'b1;
            nxt_src    = cis_pkg::src_abort;
            nxt_cnt    = {1'b0, emu_ff};
            nxt_state  = cis_pkg::st_push;
          end else if (nmi_pend_ff || (nmi_q_ff && !nonmaskable_irq_low)) begin
            nmi_take  = 1'b1;
            nxt_src   = cis_pkg::src_nmi;
            nxt_cnt   = {1'b0, emu_ff};
            nxt_state = cis_pkg::st_push;
          end else if (!maskable_irq_low && !p_ff[`CIS_P_I]) begin
            nxt_src   = cis_pkg::src_irq;
            nxt_cnt   = {1'b0, emu_ff};
            nxt_state = cis_pkg::st_push;
          end else if (instr_wr) begin
            accept    = 1'b1;
            nxt_state = cis_pkg::st_exec;
          end else if (reg_wr) begin
            case (reg_addr)
              `CIS_REG_ACC:  nxt_acc = reg_wdata[15:0];
              `CIS_REG_SP:   nxt_sp = emu_ff ? {`CIS_EMU_PAGE, reg_wdata[7:0]} : reg_wdata[15:0];
              `CIS_REG_DIR:  nxt_dir = reg_wdata[15:0];
              `CIS_REG_XIDX: nxt_xr = x8 ? {8'h00, reg_wdata[7:0]} : reg_wdata[15:0];
              `CIS_REG_PC:   nxt_pc = reg_wdata[15:0];
              `CIS_REG_BANK: begin
                nxt_dbr = reg_wdata[7:0];
                nxt_pbr = reg_wdata[15:8];
              end
              `CIS_REG_PSTAT: begin
                nxt_p   = reg_wdata[7:0];
                nxt_emu = reg_wdata[8];
                if (reg_wdata[8]) begin
                  nxt_p[`CIS_P_M] = 1'b1;
                  nxt_p[`CIS_P_X] = 1'b1;
                end
              end
              default: nxt_pc = pc_ff;
            endcase
          end
        end
        cis_pkg::st_exec: begin
          if (go) begin
            nxt_pc    = pc_ff + `CIS_LEN1;
            nxt_state = cis_pkg::st_idle;
            case (op_ff)
              `CIS_OP_TCS: begin
                // Emulation ignores the upper accumulator byte
                nxt_sp = emu_ff ? {`CIS_EMU_PAGE, acc_ff[7:0]} : acc_ff;
              end
              `CIS_OP_TSC: begin
                nxt_acc = sp_ff;
                nxt_p   = set_nz(p_ff, sp_ff, 1'b1);
              end
              `CIS_OP_TCD: nxt_dir = acc_ff;
              `CIS_OP_TDC: begin
                nxt_acc = dir_ff;
                nxt_p   = set_nz(p_ff, dir_ff, 1'b1);
              end
              `CIS_OP_TAX: begin
                // Full source, stored width follows the index width
                nxt_xr = x8 ? {8'h00, acc_ff[7:0]} : acc_ff;
                nxt_p  = set_nz(p_ff, acc_ff, !x8);
              end
              `CIS_OP_TXA: begin
                nxt_acc = m8 ? {acc_ff[15:8], xr_ff[7:0]} : xr_ff;
                nxt_p   = set_nz(p_ff, xr_ff, !m8);
              end
              `CIS_OP_LDA: begin
                nxt_acc = m8 ? {acc_ff[15:8], op1_ff} : {op2_ff, op1_ff};
                nxt_p   = set_nz(p_ff, {op2_ff, op1_ff}, !m8);
                nxt_pc  = pc_ff + (m8 ? `CIS_LEN2 : `CIS_LEN3);
              end
              `CIS_OP_SEP, `CIS_OP_REP: begin
                nxt_p = (op_ff == `CIS_OP_SEP) ? (p_ff | op1_ff) : (p_ff & ~op1_ff);
                if (emu_ff) begin
                  nxt_p[`CIS_P_M] = 1'b1;
                  nxt_p[`CIS_P_X] = 1'b1;
                end
                nxt_pc = pc_ff + `CIS_LEN2;
              end
              `CIS_OP_XCE: begin
                nxt_emu           = p_ff[`CIS_P_C];
                nxt_p[`CIS_P_C]   = emu_ff;
                if (p_ff[`CIS_P_C]) begin
                  nxt_p[`CIS_P_M] = 1'b1;
                  nxt_p[`CIS_P_X] = 1'b1;
                  nxt_sp          = {`CIS_EMU_PAGE, sp_ff[7:0]};
                  nxt_xr          = {8'h00, xr_ff[7:0]};
                end
              end
              `CIS_OP_WDM: nxt_pc = pc_ff + `CIS_LEN2;
              `CIS_OP_MVN, `CIS_OP_MVP: begin
                nxt_dbr = op1_ff;
                nxt_pc  = pc_ff + `CIS_LEN3;
              end
              `CIS_OP_PHP: begin
                // One byte whatever the mode
                mem_we    = 1'b1;
                mem_wdata = p_ff;
                nxt_sp    = sp_step(sp_ff, emu_ff, 1'b0);
              end
              `CIS_OP_PLP: nxt_state = cis_pkg::st_pull;
              `CIS_OP_WAI: nxt_state = cis_pkg::st_wait;
              `CIS_OP_BRK, `CIS_OP_COP: begin
                // Signature byte is skipped and never interpreted
                nxt_pc    = pc_ff + `CIS_LEN2;
                nxt_src   = (op_ff == `CIS_OP_BRK) ? cis_pkg::src_brk : cis_pkg::src_cop;
                nxt_cnt   = {1'b0, emu_ff};
                nxt_state = cis_pkg::st_push;
              end
              default: nxt_pc = pc_ff + `CIS_LEN1;
            endcase
          end
        end
        cis_pkg::st_push: begin
          if (go) begin
            // Bank (native mode only), return address high, low, then status
            mem_we = 1'b1;
            case (cnt_ff)
              2'b00:   mem_wdata = pbr_ff;
              2'b01:   mem_wdata = pc_ff[15:8];
              2'b10:   mem_wdata = pc_ff[7:0];
              default: mem_wdata = p_ff;
            endcase
            nxt_sp  = sp_step(sp_ff, emu_ff, 1'b0);
            nxt_cnt = cnt_ff + 2'b01;
            if (cnt_ff == 2'b11) begin
              nxt_pc          = vec;
              nxt_pbr         = 8'h00;
              nxt_dbr         = emu_ff ? 8'h00 : dbr_ff;
              nxt_p[`CIS_P_I] = 1'b1;
              nxt_p[`CIS_P_D] = 1'b0;
              nxt_state       = cis_pkg::st_idle;
            end
          end
        end
        cis_pkg::st_pull: begin
          if (go) begin
            nxt_sp    = sp_step(sp_ff, emu_ff, 1'b1);
            mem_addr  = nxt_sp[7:0];
            nxt_state = cis_pkg::st_pulld;
          end
        end
        cis_pkg::st_pulld: begin
          if (go) begin
            nxt_p = sif.rdata;
            if (emu_ff) begin
              nxt_p[`CIS_P_M] = 1'b1;
              nxt_p[`CIS_P_X] = 1'b1;
            end
            nxt_state = cis_pkg::st_idle;
          end
        end
        cis_pkg::st_wait: begin
          if (nmi_pend_ff || (nmi_q_ff && !nonmaskable_irq_low)) begin
            nmi_take  = 1'b1;
            nxt_src   = cis_pkg::src_nmi;
            nxt_cnt   = {1'b0, emu_ff};
            nxt_state = cis_pkg::st_push;
          end else if (!maskable_irq_low) begin
            // A masked request just resumes after the wait
            nxt_src   = p_ff[`CIS_P_I] ? src_ff : cis_pkg::src_irq;
            nxt_cnt   = {1'b0, emu_ff};
            nxt_state = p_ff[`CIS_P_I] ? cis_pkg::st_idle : cis_pkg::st_push;
          end
        end
        default: nxt_state = cis_pkg::st_idle;
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= cis_pkg::st_rst;
      src_ff   <= cis_pkg::src_none;
      cnt_ff   <= 2'b00;
    end else begin
      state_ff <= nxt_state;
      src_ff   <= nxt_src;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Architectural registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ff <= 16'h0000;
      sp_ff  <= `CIS_SP_RST;
      dir_ff <= 16'h0000;
      xr_ff  <= 16'h0000;
      pc_ff  <= 16'h0000;
      dbr_ff <= 8'h00;
      pbr_ff <= 8'h00;
      p_ff   <= `CIS_P_RST;
      emu_ff <= 1'b1;
    end else begin
      acc_ff <= nxt_acc;
      sp_ff  <= nxt_sp;
      dir_ff <= nxt_dir;
      xr_ff  <= nxt_xr;
      pc_ff  <= nxt_pc;
      dbr_ff <= nxt_dbr;
      pbr_ff <= nxt_pbr;
      p_ff   <= nxt_p;
      emu_ff <= nxt_emu;
    end
  end

  // Instruction bytes, taken only when the sequencer accepts them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_ff  <= 8'h00;
      op1_ff <= 8'h00;
      op2_ff <= 8'h00;
    end else if (accept) begin
      op_ff  <= reg_wdata[7:0];
      op1_ff <= reg_wdata[15:8];
      op2_ff <= reg_wdata[23:16];
    end
  end

  // Edge-caught nonmaskable and latched abort; a take consumes the event seen that cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_q_ff      <= 1'b1;
      nmi_pend_ff   <= 1'b0;
      abort_pend_ff <= 1'b0;
    end else begin
      nmi_q_ff <= nonmaskable_irq_low;
      if (!reset_input_low) begin
        nmi_pend_ff   <= 1'b0;
        abort_pend_ff <= 1'b0;
      end else begin
        nmi_pend_ff   <= ((nmi_q_ff & ~nonmaskable_irq_low) | nmi_pend_ff) & ~nmi_take;
        abort_pend_ff <= (~abort_input_low | abort_pend_ff) & ~abort_take;
      end
    end
  end

  // Sticky flag for writes the sequencer could not take; read of status clears
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refused_ff <= 1'b0;
    end else if (reg_wr && !(idle_ok && nxt_state != cis_pkg::st_push)) begin
      refused_ff <= 1'b1;
    end else if (reg_rd && reg_addr == `CIS_REG_STATUS) begin
      refused_ff <= 1'b0;
    end
  end

  // Read data mux
  always_comb begin
    case (reg_addr)
      `CIS_REG_STATUS: rd_mux = {16'h0000, p_ff, 1'b0, src_ff, refused_ff, emu_ff,
                                 (state_ff == cis_pkg::st_wait), (state_ff != cis_pkg::st_idle)};
      `CIS_REG_ACC:    rd_mux = {16'h0000, acc_ff};
      `CIS_REG_SP:     rd_mux = {16'h0000, sp_ff};
      `CIS_REG_DIR:    rd_mux = {16'h0000, dir_ff};
      `CIS_REG_XIDX:   rd_mux = {16'h0000, xr_ff};
      `CIS_REG_BANK:   rd_mux = {16'h0000, pbr_ff, dbr_ff};
      `CIS_REG_PC:     rd_mux = {16'h0000, pc_ff};
      `CIS_REG_PSTAT:  rd_mux = {23'h000000, emu_ff, p_ff};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
    end
  end
endmodule

// ===== verification/cis_core_assertions.sv
// Port-level assertions for the instruction semantics core
`timescale 1ns/100ps
module cis_core_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        reset_input_low,
  input wire logic        nonmaskable_irq_low,
  input wire logic        maskable_irq_low,
  input wire logic        bus_enable_in,
  input wire logic        ready_input,
  input wire logic        wait_state_output_low,
  input wire logic        emulation_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Core parked in the wait state with cpu reset released
  sequence s_waiting;
    !wait_state_output_low && reset_input_low;
  endsequence
  // Bus lets the sequencer advance this cycle
  sequence s_go;
    ready_input && bus_enable_in;
  endsequence

  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_RESET_FIRST: assert property (!reset_input_low |=> wait_state_output_low && emulation_mode)
    else $error("cpu reset did not win");
  AST_WAIT_ENTRY_GO: assert property ($fell(wait_state_output_low)
    |-> $past(ready_input && bus_enable_in))
    else $error("wait entered during a stall");
  AST_WAIT_HOLD: assert property (s_waiting ##0 (nonmaskable_irq_low && maskable_irq_low)
    ##0 $past(nonmaskable_irq_low) |=> !wait_state_output_low)
    else $error("wait left without a cause");
  AST_WAIT_IRQ_EXIT: assert property (s_waiting ##0 s_go ##0 !maskable_irq_low
    |-> ##[1:4] wait_state_output_low)
    else $error("maskable request did not end wait");
  AST_WAIT_NMI_EXIT: assert property (s_waiting ##0 s_go ##0 $fell(nonmaskable_irq_low)
    |-> ##[1:4] wait_state_output_low)
    else $error("nonmaskable request did not end wait");
  AST_STALL_FREEZE: assert property (!(ready_input && bus_enable_in) && reset_input_low && !reg_wr
    |=> $stable(wait_state_output_low) && $stable(emulation_mode))
    else $error("state moved during a stall");
  AST_EMU_FALL: assert property ($fell(emulation_mode) |-> $past(reset_input_low))
    else $error("native mode entered under cpu reset");
endmodule

// ===== verification/cis_sys_model.sv
// Bus-side model: the memory system's ready and bus-enable lines
`timescale 1ns/100ps
module cis_sys_model (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic stall_en,
  output logic      ready_input,
  output logic      bus_enable_in
);
  // Slow memory and bus hand-over stall only when asked, so both lines idle high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_input   <= 1'b1;
      bus_enable_in <= 1'b1;
    end else begin
      ready_input   <= !stall_en || ($urandom % 3 != 0);
      bus_enable_in <= !stall_en || ($urandom % 5 != 0);
    end
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the instruction semantics core
`timescale 1ns/100ps
`include "cis_defs.svh"
module tb_top;
  logic        clk, sys_rst, reg_wr, reg_rd, stall_en, ready_input, bus_enable_in;
  logic        reset_input_low, abort_input_low, nonmaskable_irq_low, maskable_irq_low;
  logic        wait_state_output_low, emulation_mode;
  logic [5:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] v, x, s, p, q;
  logic [15:0] snap [5];
  logic [5:0]  regs [5];
  int          n_mismatch, comparisons, k;

  cis_core dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_input_low(reset_input_low), .abort_input_low(abort_input_low),
    .nonmaskable_irq_low(nonmaskable_irq_low), .maskable_irq_low(maskable_irq_low), .bus_enable_in(bus_enable_in),
    .ready_input(ready_input), .wait_state_output_low(wait_state_output_low), .emulation_mode(emulation_mode));
  cis_sys_model u_sys (.clk(clk), .sys_rst(sys_rst), .stall_en(stall_en), .ready_input(ready_input),
    .bus_enable_in(bus_enable_in));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata[15:0];
  endtask
  task automatic rchk(input string name, input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask
  function automatic logic [31:0] ins(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    return {8'h00, b3, b2, op};
  endfunction
  // Issue one instruction, then poll busy under a bound so a hang shows
  task automatic run(input logic [31:0] w);
    logic [15:0] st;
    int i;
    wr(`CIS_REG_INSTR, w);
    for (i = 0; i < 80; i++) begin
      rd(`CIS_REG_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    if (i == 80) begin
      n_mismatch++;
      $display("[ERR] busy expected 0 seen 1");
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run of a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    {sys_rst, reset_input_low, abort_input_low, nonmaskable_irq_low, maskable_irq_low} = 5'h1f;
    {reg_wr, reg_rd, stall_en, reg_addr, reg_wdata} = '0;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(58068));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rchk("sp", `CIS_REG_SP, `CIS_SP_RST);
    rchk("pstat", `CIS_REG_PSTAT, {8'h01, `CIS_P_RST});
    // Emulation stack transfers, with random stalls from the bus side
    repeat (4) begin
      v = 16'($urandom);
      stall_en = 1'($urandom);
      wr(`CIS_REG_ACC, {16'h0, v});
      run(ins(`CIS_OP_TCS, 8'h00, 8'h00));
      rchk("sp", `CIS_REG_SP, {`CIS_EMU_PAGE, v[7:0]});
      run(ins(`CIS_OP_TSC, 8'h00, 8'h00));
      rchk("acc", `CIS_REG_ACC, {`CIS_EMU_PAGE, v[7:0]});
    end
    stall_en = 1'b0;
    // Native mode, then the width sequence that keeps the upper byte
    run(ins(`CIS_OP_REP, 8'h01, 8'h00));
    run(ins(`CIS_OP_XCE, 8'h00, 8'h00));
    run(ins(`CIS_OP_REP, 8'h30, 8'h00));
    run(ins(`CIS_OP_LDA, 8'h45, 8'h23));
    run(ins(`CIS_OP_SEP, 8'h20, 8'h00));
    run(ins(`CIS_OP_LDA, 8'h01, 8'h00));
    run(ins(`CIS_OP_REP, 8'h20, 8'h00));
    rchk("acc", `CIS_REG_ACC, 16'h2301);
    run(ins(`CIS_OP_SEP, 8'h20, 8'h00));
    run(ins(`CIS_OP_TCD, 8'h00, 8'h00));
    rchk("dir", `CIS_REG_DIR, 16'h2301);
    v = 16'($urandom);
    x = 16'($urandom);
    wr(`CIS_REG_DIR, {16'h0, v});
    run(ins(`CIS_OP_TDC, 8'h00, 8'h00));
    rchk("acc", `CIS_REG_ACC, v);
    wr(`CIS_REG_XIDX, {16'h0, x});
    run(ins(`CIS_OP_TXA, 8'h00, 8'h00));
    rchk("acc", `CIS_REG_ACC, {v[15:8], x[7:0]});
    run(ins(`CIS_OP_TAX, 8'h00, 8'h00));
    rchk("xidx", `CIS_REG_XIDX, {v[15:8], x[7:0]});
    run(ins(`CIS_OP_TCS, 8'h00, 8'h00));
    rchk("sp", `CIS_REG_SP, {v[15:8], x[7:0]});
    // Both block moves load the bank from byte two
    for (k = 0; k < 2; k++) begin
      v = 16'($urandom);
      rd(`CIS_REG_PC, p);
      run(ins(k ? `CIS_OP_MVP : `CIS_OP_MVN, v[7:0], v[15:8]));
      rd(`CIS_REG_BANK, q);
      chk("bank", {8'h00, v[7:0]}, {8'h00, q[7:0]});
      rchk("pc", `CIS_REG_PC, p + `CIS_LEN3);
    end
    regs = '{`CIS_REG_ACC, `CIS_REG_SP, `CIS_REG_DIR, `CIS_REG_XIDX, `CIS_REG_PSTAT};
    for (k = 0; k < 5; k++) rd(regs[k], snap[k]);
    rd(`CIS_REG_PC, p);
    run(ins(`CIS_OP_WDM, 8'($urandom), 8'h00));
    for (k = 0; k < 5; k++) rchk("kept", regs[k], snap[k]);
    rchk("pc", `CIS_REG_PC, p + `CIS_LEN2);
    // Break under stalls: pushes are writes and must wait too
    rd(`CIS_REG_SP, s);
    rd(`CIS_REG_PC, p);
    stall_en = 1'b1;
    run(ins(`CIS_OP_BRK, 8'($urandom), 8'h00));
    stall_en = 1'b0;
    rchk("pc", `CIS_REG_PC, `CIS_VEC_BRK);
    rchk("sp", `CIS_REG_SP, s - 16'h4);
    run(ins(`CIS_OP_PLP, 8'h00, 8'h00));
    rchk("sp", `CIS_REG_SP, s - 16'h3);
    run(ins(`CIS_OP_PLP, 8'h00, 8'h00));
    rd(`CIS_REG_PSTAT, q);
    chk("ret_lo", {8'h00, p[7:0] + 8'h02}, {8'h00, q[7:0]});
    rd(`CIS_REG_SP, s);
    run(ins(`CIS_OP_COP, {1'b0, 7'($urandom)}, 8'h00));
    rchk("sp", `CIS_REG_SP, s - 16'h4);
    // Two requests at once: abort or nonmaskable beats maskable
    for (k = 0; k < 2; k++) begin
      wr(`CIS_REG_PSTAT, 32'h0);
      rd(`CIS_REG_SP, s);
      @(posedge clk);
      abort_input_low     <= (k != 0);
      nonmaskable_irq_low <= (k == 0);
      maskable_irq_low    <= 1'b0;
      @(posedge clk);
      abort_input_low <= 1'b1;
      repeat (30) @(posedge clk);
      {nonmaskable_irq_low, maskable_irq_low} <= 2'b11;
      rchk("vector", `CIS_REG_PC, k ? `CIS_VEC_NMI : `CIS_VEC_ABORT);
      rchk("sp", `CIS_REG_SP, s - 16'h4);
    end
    // Wait ended by masked request, nonmaskable, then cpu reset over both requests
    for (k = 0; k < 3; k++) begin
      rd(`CIS_REG_PC, p);
      wr(`CIS_REG_INSTR, ins(`CIS_OP_WAI, 8'h00, 8'h00));
      repeat (4) @(posedge clk);
      #1 chk("wait_out", 16'h0, {15'h0, wait_state_output_low});
      @(posedge clk);
      maskable_irq_low    <= (k == 1);
      nonmaskable_irq_low <= (k == 0);
      reset_input_low     <= (k != 2);
      repeat (8) @(posedge clk);
      {maskable_irq_low, nonmaskable_irq_low, reset_input_low} <= 3'b111;
      repeat (10) @(posedge clk);
      #1 chk("wait_out", 16'h1, {15'h0, wait_state_output_low});
      rchk("pc", `CIS_REG_PC, (k == 0) ? p + `CIS_LEN1 : (k == 1) ? `CIS_VEC_NMI : `CIS_VEC_RESET);
    end
    chk("emu", 16'h1, {15'h0, emulation_mode});
    conclude();
  end
endmodule

bind cis_core cis_core_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reset_input_low(reset_input_low), .nonmaskable_irq_low(nonmaskable_irq_low),
  .maskable_irq_low(maskable_irq_low), .bus_enable_in(bus_enable_in), .ready_input(ready_input),
  .wait_state_output_low(wait_state_output_low), .emulation_mode(emulation_mode));
